// >>> rtl/elpr_pkg.sv
// Constants and register map for the error log and constants recall block.
// Assumes a 16-bit word-addressed register port on the module clock.
package elpr_pkg;
  localparam int          ADDR_W         = 13;
  localparam int          DATA_W         = 16;
  localparam int          NCH            = 4;
  localparam int          REC_WORDS      = 16;
  localparam int          NSLOTS         = 15;
  localparam int          REC_FIELDS     = 10;                // Words 10..15 are system area
  localparam logic [12:0] OFS_LOG_BASE   = 13'h0a00;
  localparam logic [12:0] OFS_LOG_OLDER  = 13'h0a10;
  localparam logic [12:0] OFS_LOG_END    = 13'h0aef;
  localparam logic [12:0] OFS_CLR_CMD    = 13'h1000;
  localparam logic [12:0] OFS_CLR_DONE   = 13'h1001;
  localparam logic [12:0] OFS_RECALL     = 13'h1100;
  localparam logic [12:0] OFS_RESULT     = 13'h1104;
  localparam logic [12:0] OFS_BACKUP_EN  = 13'h1108;         // Per-channel auto backup enable, 4 words
  localparam logic [12:0] OFS_ATREQ      = 13'h110c;         // Tuning request bits 3:0
  localparam logic [12:0] OFS_CONST_BASE = 13'h1110;         // Working constants, 5 words per channel
  localparam int          NCONST         = 5;
  localparam int          RD_DONE_POS    = 0;
  localparam int          WR_DONE_POS    = 4;
  localparam int          RD_FAIL_POS    = 8;
  localparam int          WR_FAIL_POS    = 12;
  localparam logic [15:0] CLR_CMD_RST    = 16'h0000;
  localparam logic [15:0] CLR_DONE_RST   = 16'h0000;
  localparam logic [15:0] RECALL_RST     = 16'h0000;
  localparam int          NV_LAT         = 8;                // Store op count; each op spans NV_LAT+1 cycles
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_RECALL} elpr_state_t;
endpackage : elpr_pkg

// >>> rtl/elpr_top.sv
// Error log, log clear and constants recall logic with result flags.
// Assumes a nonvolatile store modelled as a fixed op time and an external fail answer per op.
`timescale 1ns/1ps
module elpr_top #(
  parameter int NV_CYCLES = elpr_pkg::NV_LAT
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        clk_en,          // Low freezes all state except reset
  input  wire logic [12:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        err_valid,       // One-cycle pulse: new error record
  input  wire logic [15:0] err_code,
  input  wire logic [15:0] err_addr,
  input  wire logic [15:0] err_time [4],    // BCD timestamp words
  input  wire logic [15:0] err_process_value,
  input  wire logic [15:0] err_output_value,
  input  wire logic [15:0] err_setpoint_value,
  input  wire logic        nv_fail,         // Nonvolatile op failure level
  input  wire logic [15:0] nv_const [4][5], // Backed-up constants per channel
  input  wire logic [3:0]  tune_end,        // Pulse: tuning finished per channel
  output logic      [3:0]  autotune_active_bits
);
  localparam int CW = $clog2(NV_CYCLES + 1);
  localparam logic CLR_CMD_RST_B = elpr_pkg::CLR_CMD_RST[0];  // Reset level of clear command

  // Address map, one 16-bit word each:
  //   0x0a00-0x0aef  error log slots
  //   0x1000         clear command
  //   0x1001         clear done
  //   0x1100-0x1103  recall requests
  //   0x1104         result flags
  //   0x1108-0x110b  auto backup enables
  //   0x110c         tuning requests
  //   0x1110-0x1123  working constants
  // Other addresses read zero and drop
  // writes, so probing has no side effect.
  //
  // The counter width follows NV_CYCLES,
  // so a bench may shrink the store time
  // without touching any other logic.
  //
  // Every process but its reset is gated
  // by clk_en; with it low only a reset
  // moves any state.
  //
  // The store itself is outside: this
  // block only sees a failure level that
  // it samples at the end of each job,
  // and the backed-up words it copies.

  // Held state. The log is flip-flops,
  // indexed by slot and word. Only the
  // ten meaningful words of a record are
  // kept; the six system words read zero,
  // which saves over a third of storage.
  //
  // Control words keep bit 0 only, or the
  // low nibble for tuning requests, since
  // the rest always reads zero.

  // Log storage: slot 0 newest
  logic [15:0] log_q [elpr_pkg::NSLOTS][elpr_pkg::REC_FIELDS];
  logic [15:0] order_q;                       // Running occurrence number
  logic        clr_cmd_q;
  logic        clr_done_q;
  logic [3:0]  recall_q;
  logic [3:0]  recall_prev_q;
  logic [3:0]  backup_en_q;
  logic [3:0]  atreq_q;
  logic [15:0] result_q;
  logic [15:0] const_q [4][5];                // Working buffer
  logic [3:0]  pend_q;                        // Recall waiting for service
  logic [1:0]  ch_q;
  logic [CW-1:0] cnt_q;
  elpr_pkg::elpr_state_t st_q;

  // A new error enters slot 0 and each
  // slot moves one down. Slot 14 takes
  // slot 13, so the oldest record falls
  // off once fifteen are held; no entry
  // count is needed for that.
  //
  // The occurrence number keeps running
  // across erases, so software can still
  // tell how many errors occurred.
  //
  // An erase ending on the edge of a new
  // error wins and that error is lost; a
  // real store is busy then as well, and
  // a lost record beats a half-clear log.

  // Shift-in and erase of the log
  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int s = 0; s < elpr_pkg::NSLOTS; s++)
        for (int w = 0; w < elpr_pkg::REC_FIELDS; w++)
          log_q[s][w] <= 16'h0000;
      order_q <= 16'h0000;
    end else if (clk_en) begin
      if (st_q == elpr_pkg::ST_ERASE && cnt_q == CW'(NV_CYCLES) && !nv_fail) begin
        for (int s = 0; s < elpr_pkg::NSLOTS; s++)
          for (int w = 0; w < elpr_pkg::REC_FIELDS; w++)
            log_q[s][w] <= 16'h0000;
      end else if (err_valid) begin
        // Oldest slot falls off the end when full
        for (int s = elpr_pkg::NSLOTS - 1; s > 0; s--)
          log_q[s] <= log_q[s-1];
        log_q[0][0] <= err_code;
        log_q[0][1] <= order_q + 16'h0001;
        for (int t = 0; t < 4; t++)
          log_q[0][2+t] <= err_time[t];
        log_q[0][6] <= err_addr;
        log_q[0][7] <= err_process_value;
        log_q[0][8] <= err_output_value;
        log_q[0][9] <= err_setpoint_value;
        order_q     <= order_q + 16'h0001;
      end
    end
  end

  // Host writes are taken on an edge with
  // clk_en high. There is no wait state,
  // so software never stalls.
  // Only bit 0 of the clear and recall
  // words is stored; that is what makes
  // their upper bits read back as zero.
  // Backup enables and tuning requests
  // sit here as plain host words too.
  //
  // Software-written control words
  always_ff @(posedge clock) begin
    if (!resetn) begin
      clr_cmd_q   <= CLR_CMD_RST_B;
      recall_q    <= 4'h0;
      backup_en_q <= 4'h0;
      atreq_q     <= 4'h0;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == elpr_pkg::OFS_CLR_CMD)
        clr_cmd_q <= reg_wdata[0];
      for (int c = 0; c < elpr_pkg::NCH; c++) begin
        if (reg_addr == elpr_pkg::OFS_RECALL + 13'(c))
          recall_q[c] <= reg_wdata[0];
        if (reg_addr == elpr_pkg::OFS_BACKUP_EN + 13'(c))
          backup_en_q[c] <= reg_wdata[0];
      end
      if (reg_addr == elpr_pkg::OFS_ATREQ)
        atreq_q <= reg_wdata[3:0];
    end
  end

  // One sequencer owns the store, so an
  // erase and a recall never overlap.
  // Erase goes first: a clear holds off
  // recalls until it is answered.
  // Among channels the lowest is served
  // first; a high channel waits while any
  // lower one or a clear is pending.
  //
  // A recall is armed by a rising request
  // and not by its level, so a request
  // left high does not reload the buffer
  // again and again. A failed recall is
  // retried by lowering and raising the
  // request, which arms it once more.
  //
  // A tuning request on a channel drops
  // and blocks its recall: the tuner owns
  // those constants while it runs.

  // Sequencer: one nonvolatile operation at a time
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_q          <= elpr_pkg::ST_IDLE;
      cnt_q         <= '0;
      ch_q          <= 2'd0;
      pend_q        <= 4'h0;
      recall_prev_q <= 4'h0;
      clr_done_q    <= elpr_pkg::CLR_DONE_RST[0];
    end else if (clk_en) begin
      recall_prev_q <= recall_q;
      // Rising request not under tuning arms a recall, any run state
      for (int c = 0; c < elpr_pkg::NCH; c++) begin
        if (recall_q[c] && !recall_prev_q[c] && !atreq_q[c])
          pend_q[c] <= 1'b1;
        else if (!recall_q[c] || atreq_q[c])
          pend_q[c] <= 1'b0;
      end
      if (!clr_cmd_q)
        clr_done_q <= 1'b0;
      unique case (st_q)
        // Idle parks the counter at zero and
        // picks the next job. The loop runs
        // downward, so the last match, the
        // lowest channel, is the one kept.
        elpr_pkg::ST_IDLE: begin
          cnt_q <= '0;
          if (clr_cmd_q && !clr_done_q)
            st_q <= elpr_pkg::ST_ERASE;
          else begin
            for (int c = elpr_pkg::NCH - 1; c >= 0; c--)
              if (pend_q[c] && recall_q[c] && !atreq_q[c]) begin
                ch_q <= 2'(c);
                st_q <= elpr_pkg::ST_RECALL;
              end
          end
        end
        // Erase runs NV_CYCLES+1 edges; the
        // log is wiped on the last one.
        elpr_pkg::ST_ERASE: begin
          cnt_q <= cnt_q + CW'(1);
          if (cnt_q == CW'(NV_CYCLES)) begin
            // A failed erase is retried from idle while the command stands
            if (!nv_fail && clr_cmd_q)
              clr_done_q <= 1'b1;
            st_q <= elpr_pkg::ST_IDLE;
          end
        end
        // Recall runs the same length; the
        // buffer and flags update on the last
        // edge, then the job is retired.
        elpr_pkg::ST_RECALL: begin
          cnt_q <= cnt_q + CW'(1);
          if (cnt_q == CW'(NV_CYCLES)) begin
            pend_q[ch_q] <= 1'b0;
            st_q         <= elpr_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // The buffer is overwritten only at the
  // end of a good recall. On a failure the
  // old constants stay in force, so the
  // loop never runs on half-read values.
  //
  // Values reach control only when the host
  // asks; this block just holds the words.
  // After reset the buffer is zero until
  // the first good recall of each channel.
  //
  // Working constants reloaded only on good recall
  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int c = 0; c < elpr_pkg::NCH; c++)
        for (int k = 0; k < elpr_pkg::NCONST; k++)
          const_q[c][k] <= 16'h0000;
    end else if (clk_en) begin
      if (st_q == elpr_pkg::ST_RECALL && cnt_q == CW'(NV_CYCLES) && !nv_fail)
        const_q[ch_q] <= nv_const[ch_q];
    end
  end

  // Result flags, one bit per channel:
  //   3:0  read done    11:8   read fail
  //   7:4  write done   15:12  write fail
  // Done flags are set by a good end and
  // cleared by the host lowering request
  // or enable. If both land on one edge,
  // the set wins and no completion is lost.
  //
  // Failure flags are rewritten at every
  // attempt's end: failure sets, success
  // alone clears. A failure leaves done
  // as it was, so an old success can sit
  // beside a new failure.
  //
  // A backup write counts as ended on the
  // tuning end pulse; the store's failure
  // level at that pulse decides.
  //
  // Result flags per channel
  genvar g;
  generate
    for (g = 0; g < elpr_pkg::NCH; g++) begin : g_flag
      logic rd_end;
      logic wr_end;
      assign rd_end = (st_q == elpr_pkg::ST_RECALL) && (cnt_q == CW'(NV_CYCLES)) && (ch_q == 2'(g));
      assign wr_end = tune_end[g] && backup_en_q[g];
      always_ff @(posedge clock) begin
        if (!resetn) begin
          result_q[elpr_pkg::RD_DONE_POS+g] <= 1'b0;
          result_q[elpr_pkg::RD_FAIL_POS+g] <= 1'b0;
          result_q[elpr_pkg::WR_DONE_POS+g] <= 1'b0;
          result_q[elpr_pkg::WR_FAIL_POS+g] <= 1'b0;
        end else if (clk_en) begin
          // Set wins over clear on the same cycle
          if (rd_end && !nv_fail)
            result_q[elpr_pkg::RD_DONE_POS+g] <= 1'b1;
          else if (!recall_q[g])
            result_q[elpr_pkg::RD_DONE_POS+g] <= 1'b0;
          if (rd_end)
            result_q[elpr_pkg::RD_FAIL_POS+g] <= nv_fail;
          if (wr_end && !nv_fail)
            result_q[elpr_pkg::WR_DONE_POS+g] <= 1'b1;
          else if (!backup_en_q[g])
            result_q[elpr_pkg::WR_DONE_POS+g] <= 1'b0;
          if (wr_end)
            result_q[elpr_pkg::WR_FAIL_POS+g] <= nv_fail;
        end
      end
      // Status rises with the tuning request
      // and falls when tuning ends. With auto
      // backup on it stays up after the end,
      // until the host lowers both the enable and the request; that
      // tells us the write flags were seen.
      // Tuning status: on at request, held after end while backup enabled
      always_ff @(posedge clock) begin
        if (!resetn)
          autotune_active_bits[g] <= 1'b0;
        else if (clk_en) begin
          if (atreq_q[g] && !tune_end[g])
            autotune_active_bits[g] <= 1'b1;
          else if (tune_end[g])
            autotune_active_bits[g] <= backup_en_q[g];
          else if (!backup_en_q[g] && !atreq_q[g])
            autotune_active_bits[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Read data appear on the edge after the
  // strobe and hold until the next read, so
  // a slow host may sample late.
  //
  // Unmapped words and system words return
  // zero. Decode is a flat set of compares;
  // later matches win but ranges never
  // overlap, so order does not matter.
  //
  // The slot index is address bits 7:4,
  // which works because the log starts on
  // a 256-word boundary.
  //
  // Read port, data one cycle after strobe; unmapped reads zero
  always_ff @(posedge clock) begin
    if (!resetn)
      reg_rdata <= 16'h0000;
    else if (clk_en && reg_rd) begin
      reg_rdata <= 16'h0000;
      if (reg_addr >= elpr_pkg::OFS_LOG_BASE && reg_addr <= elpr_pkg::OFS_LOG_END) begin
        if (reg_addr[3:0] < 4'(elpr_pkg::REC_FIELDS))
          reg_rdata <= log_q[reg_addr[7:4]][reg_addr[3:0]];
      end
      if (reg_addr == elpr_pkg::OFS_CLR_CMD)
        reg_rdata <= {15'h0000, clr_cmd_q};
      if (reg_addr == elpr_pkg::OFS_CLR_DONE)
        reg_rdata <= {15'h0000, clr_done_q};
      if (reg_addr == elpr_pkg::OFS_RESULT)
        reg_rdata <= result_q;
      if (reg_addr == elpr_pkg::OFS_ATREQ)
        reg_rdata <= {12'h000, atreq_q};
      for (int c = 0; c < elpr_pkg::NCH; c++) begin
        if (reg_addr == elpr_pkg::OFS_RECALL + 13'(c))
          reg_rdata <= {15'h0000, recall_q[c]};
        if (reg_addr == elpr_pkg::OFS_BACKUP_EN + 13'(c))
          reg_rdata <= {15'h0000, backup_en_q[c]};
        for (int k = 0; k < elpr_pkg::NCONST; k++)
          if (reg_addr == elpr_pkg::OFS_CONST_BASE + 13'(c*elpr_pkg::NCONST + k))
            reg_rdata <= const_q[c][k];
      end
    end
  end
  // Applying recalled constants to control is the host's toggle, outside this block
  // The host toggles the initial data
  // request with all channels stopped, or
  // the run-time change request, before
  // reloaded values reach the loop.
  //
  // Limitations:
  //  - A recall whose request falls early
  //    still ends; its done flag is set and
  //    dropped on the next edge.
  //  - One store job runs at a time; other
  //    requests wait in the pending bits.
  //  - A tuning end with backup off leaves
  //    both write flags alone.
endmodule : elpr_top

// >>> tb/elpr_top_monitor.sv
// Checker for the error log and recall block, bound to elpr_top.
// Assumes host writes land at the strobe edge and the block freezes while clk_en is low.
`timescale 1ns/1ps
module elpr_top_monitor #(
  parameter int NV_CYCLES = 8
) (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        clk_en,
  input wire logic [12:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [3:0]  autotune_active_bits
);
  logic [3:0]      rq_q, rq_h1, rq_h2, bk_q, bk_h1, bk_h2; // Host shadows with two cycles of history
  logic [2:0]      cq_q;                                   // Clear command shadow, history above bit 0
  wire logic [3:0] rq_any = rq_q | rq_h1 | rq_h2;          // Flags may lag a falling request
  wire logic [3:0] bk_any = bk_q | bk_h1 | bk_h2;
  wire logic       rd_ok  = reg_rd && clk_en;              // A read is only taken with clk_en high
  // Shadows track what the host last wrote
  always_ff @(posedge clock) begin
    if (!resetn) begin
      {rq_q, rq_h1, rq_h2, bk_q, bk_h1, bk_h2, cq_q} <= '0;
    end else if (clk_en) begin
      {rq_h2, rq_h1, bk_h2, bk_h1, cq_q[2:1]} <= {rq_h1, rq_q, bk_h1, bk_q, cq_q[1:0]};
      if (reg_wr && reg_addr[12:2] == elpr_pkg::OFS_RECALL[12:2]) begin
        rq_q[reg_addr[1:0]] <= reg_wdata[0];
      end
      if (reg_wr && reg_addr[12:2] == elpr_pkg::OFS_BACKUP_EN[12:2]) begin
        bk_q[reg_addr[1:0]] <= reg_wdata[0];
      end
      if (reg_wr && reg_addr == elpr_pkg::OFS_CLR_CMD) begin
        cq_q[0] <= reg_wdata[0];
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_cmd_hi; rd_ok && reg_addr == elpr_pkg::OFS_CLR_CMD |=> reg_rdata[15:1] == 15'h0000; endproperty
  a_cmd_hi: assert property (p_cmd_hi) else $error("clear command upper bits not zero");
  property p_done_hi; rd_ok && reg_addr == elpr_pkg::OFS_CLR_DONE |=> reg_rdata[15:1] == 15'h0000; endproperty
  a_done_hi: assert property (p_done_hi) else $error("clear done upper bits not zero");
  property p_cmd_rb; rd_ok && reg_addr == elpr_pkg::OFS_CLR_CMD |=> reg_rdata[0] == $past(cq_q[0]); endproperty
  a_cmd_rb: assert property (p_cmd_rb) else $error("clear command readback wrong");
  property p_done_drop;
    rd_ok && reg_addr == elpr_pkg::OFS_CLR_DONE && cq_q == 3'h0 |=> reg_rdata[0] == 1'b0;
  endproperty
  a_done_drop: assert property (p_done_drop) else $error("clear done high without command");
  property p_sys_area;
    rd_ok && reg_addr >= elpr_pkg::OFS_LOG_BASE && reg_addr <= elpr_pkg::OFS_LOG_END && reg_addr[3:0] >= 4'ha
      |=> reg_rdata == 16'h0000;
  endproperty
  a_sys_area: assert property (p_sys_area) else $error("record system word not zero");
  property p_rd_done; rd_ok && reg_addr == elpr_pkg::OFS_RESULT |=> (reg_rdata[3:0] & ~$past(rq_any)) == 4'h0; endproperty
  a_rd_done: assert property (p_rd_done) else $error("read done without request");
  property p_wr_done; rd_ok && reg_addr == elpr_pkg::OFS_RESULT |=> (reg_rdata[7:4] & ~$past(bk_any)) == 4'h0; endproperty
  a_wr_done: assert property (p_wr_done) else $error("write done without backup enabled");
  property p_tune_hold; (($past(autotune_active_bits) & bk_q) & ~autotune_active_bits) == 4'h0; endproperty
  a_tune_hold: assert property (p_tune_hold) else $error("tuning status dropped with backup on");
endmodule : elpr_top_monitor
bind elpr_top elpr_top_monitor #(.NV_CYCLES(NV_CYCLES)) u_mon (
  .clock(clock), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .autotune_active_bits(autotune_active_bits));

// >>> tb/elpr_nv_model.sv
// Nonvolatile store stand-in: backed-up constants and a failure answer.
// Assumes the bench raises fail_req only where a scenario wants a fault.
`timescale 1ns/1ps
module elpr_nv_model (
  input  wire logic        clock,
  input  wire logic        fail_req,        // Bench asks for failing operations
  output logic             nv_fail,         // Failure level seen by the block
  output logic      [15:0] nv_const [4][5]  // Stored constants per channel
);
  // Registered, so a fault request lands one edge later like a real status line
  always_ff @(posedge clock) begin
    nv_fail <= fail_req;
  end
  // Distinct word per channel and slot, so a swapped copy is caught
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 5; k++) begin
        nv_const[c][k] = 16'h1000 + 16'(c * 16 + k);
      end
    end
  end
endmodule : elpr_nv_model

// >>> tb/elpr_top_tb.sv
// Self-checking bench for elpr_top: register tasks and a scenario sequence.
// Assumes elpr_nv_model as the store and a shortened nonvolatile count.
`timescale 1ns/1ps
module elpr_top_tb;
  localparam int NVC = 2;                // Short store operation keeps the run brief
  logic        clock, resetn, clk_en, reg_wr, reg_rd, err_valid, nv_fail, fail_req;
  logic [12:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, err_code, err_addr, err_process_value, err_output_value, err_setpoint_value;
  logic [15:0] err_time [4];
  logic [15:0] nv_const [4][5];
  logic [3:0]  tune_end, active;
  int          fail_count, checked;
  elpr_top #(.NV_CYCLES(NVC)) u_dut (
    .clock(clock), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .err_valid(err_valid), .err_code(err_code),
    .err_addr(err_addr), .err_time(err_time), .err_process_value(err_process_value),
    .err_output_value(err_output_value), .err_setpoint_value(err_setpoint_value),
    .nv_fail(nv_fail), .nv_const(nv_const), .tune_end(tune_end), .autotune_active_bits(active));
  elpr_nv_model u_nv (.clock(clock), .fail_req(fail_req), .nv_fail(nv_fail), .nv_const(nv_const));
  // Free-running 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  // Four-state compare, so an unknown never passes
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [12:0] a, input logic [15:0] d);
    @(posedge clock);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data appear in the cycle after the strobe and hold until the next read
  task automatic rc(input logic [12:0] a, input logic [15:0] e);
    @(posedge clock);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rc
  task automatic push(input logic [15:0] i);
    @(posedge clock);
    {err_valid, err_code, err_addr, err_process_value} <= {1'b1, i, i + 16'h0080, i + 16'h0100};
    @(posedge clock);
    err_valid <= 1'b0;
  endtask : push
  task automatic tune(input logic [3:0] m);
    @(posedge clock);
    tune_end <= m;
    @(posedge clock);
    tune_end <= 4'h0;
    cyc(2);
  endtask : tune
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask : fin
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    cyc(3000);
    fail_count++;
    test_done();
  end
  initial begin
    {resetn, clk_en, reg_wr, reg_rd, err_valid, fail_req} = 6'b010000;
    {reg_addr, reg_wdata, err_code, err_addr, err_process_value, err_output_value, err_setpoint_value, tune_end} = '0;
    err_time = '{16'h2012, 16'h0901, 16'h1330, 16'h5000};
    fail_count = 0;
    checked = 0;
    cyc(10);
    resetn <= 1'b1;
    rc(elpr_pkg::OFS_CLR_CMD, 16'h0000);
    rc(elpr_pkg::OFS_CLR_DONE, 16'h0000);
    for (int c = 0; c < 4; c++) rc(elpr_pkg::OFS_RECALL + 13'(c), 16'h0000);
    wr(elpr_pkg::OFS_RECALL, 16'h0001);
    cyc(NVC + 6);
    rc(elpr_pkg::OFS_RESULT, 16'h0001);
    for (int k = 0; k < 5; k++) rc(elpr_pkg::OFS_CONST_BASE + 13'(k), 16'h1000 + 16'(k));
    wr(elpr_pkg::OFS_RECALL, 16'h0000);
    cyc(2);
    rc(elpr_pkg::OFS_RESULT, 16'h0000);
    fail_req <= 1'b1;
    wr(elpr_pkg::OFS_RECALL + 13'h1, 16'h0001);
    cyc(NVC + 6);
    rc(elpr_pkg::OFS_RESULT, 16'h0200);
    rc(elpr_pkg::OFS_CONST_BASE + 13'h5, 16'h0000);
    fail_req <= 1'b0;
    wr(elpr_pkg::OFS_RECALL + 13'h1, 16'h0000);
    wr(elpr_pkg::OFS_RECALL + 13'h1, 16'h0001);
    cyc(NVC + 6);
    rc(elpr_pkg::OFS_RESULT, 16'h0002);
    wr(elpr_pkg::OFS_RECALL + 13'h1, 16'h0000);
    wr(elpr_pkg::OFS_ATREQ, 16'h0004);
    wr(elpr_pkg::OFS_RECALL + 13'h2, 16'h0001);
    cyc(NVC + 6);
    rc(elpr_pkg::OFS_RESULT, 16'h0000);
    wr(elpr_pkg::OFS_RECALL + 13'h2, 16'h0000);
    fin("recall");
    wr(elpr_pkg::OFS_ATREQ, 16'h0008);
    wr(elpr_pkg::OFS_BACKUP_EN + 13'h3, 16'h0001);
    tune(4'h8);
    rc(elpr_pkg::OFS_RESULT, 16'h0080);
    fail_req <= 1'b1;
    tune(4'h8);
    rc(elpr_pkg::OFS_RESULT, 16'h8080);
    fail_req <= 1'b0;
    tune(4'h8);
    rc(elpr_pkg::OFS_RESULT, 16'h0080);
    wr(elpr_pkg::OFS_ATREQ, 16'h0000);
    cyc(2);
    #1 chk({12'h000, active}, 16'h0008);
    wr(elpr_pkg::OFS_BACKUP_EN + 13'h3, 16'h0000);
    cyc(2);
    #1 chk({12'h000, active}, 16'h0000);
    rc(elpr_pkg::OFS_RESULT, 16'h0000);
    fin("backup");
    for (int i = 1; i <= 17; i++) push(16'(i));
    cyc(2);
    rc(elpr_pkg::OFS_LOG_BASE, 16'h0011);
    rc(elpr_pkg::OFS_LOG_BASE + 13'h2, 16'h2012);
    rc(elpr_pkg::OFS_LOG_BASE + 13'h6, 16'h0091);
    rc(elpr_pkg::OFS_LOG_BASE + 13'h7, 16'h0111);
    rc(elpr_pkg::OFS_LOG_BASE + 13'ha, 16'h0000);
    rc(elpr_pkg::OFS_LOG_OLDER, 16'h0010);
    rc(elpr_pkg::OFS_LOG_END - 13'hf, 16'h0003);
    fin("log");
    wr(elpr_pkg::OFS_CLR_CMD, 16'hffff);
    rc(elpr_pkg::OFS_CLR_CMD, 16'h0001);
    cyc(NVC + 6);
    rc(elpr_pkg::OFS_CLR_DONE, 16'h0001);
    rc(elpr_pkg::OFS_LOG_BASE, 16'h0000);
    wr(elpr_pkg::OFS_CLR_CMD, 16'h0000);
    cyc(2);
    rc(elpr_pkg::OFS_CLR_DONE, 16'h0000);
    fin("clear");
    // A write with clk_en low must not be taken
    @(posedge clock);
    clk_en <= 1'b0;
    wr(elpr_pkg::OFS_CLR_CMD, 16'h0001);
    clk_en <= 1'b1;
    rc(elpr_pkg::OFS_CLR_CMD, 16'h0000);
    // Reset in mid-run returns the control words to zero
    wr(elpr_pkg::OFS_RECALL + 13'h3, 16'h0001);
    wr(elpr_pkg::OFS_CLR_CMD, 16'h0001);
    resetn <= 1'b0;
    cyc(2);
    resetn <= 1'b1;
    rc(elpr_pkg::OFS_RECALL + 13'h3, 16'h0000);
    rc(elpr_pkg::OFS_CLR_CMD, 16'h0000);
    fin("reset");
    test_done();
  end
endmodule : elpr_top_tb
